// ### src/tss_pkg.sv
// constants, field layouts and carrier types of the time-slot switch block
// assumes one master clock domain; all widths below are shared with the bench
package tss_pkg;

  // clocking and frame timing
  localparam int MCLK_HZ        = 40000000;             // rate of mclk
  localparam int MASTER_HZ      = 16384000;             // nominal master state rate
  localparam int FRAME_HZ       = 8000;                 // frame rate
  localparam int FRAME_STATES   = MASTER_HZ / FRAME_HZ; // 2048 states per frame
  localparam int SLOT_STATES    = 4;                    // states spent on one channel slot
  localparam int DPLL_DIV       = 4;                    // master to 4.096 MHz divide
  localparam logic [10:0] FRAME_LAST = 11'(FRAME_STATES - 1);

  // channel counts
  localparam int NUM_CHAN       = 384;                  // total channels
  localparam logic [8:0] CHAN_LAST = 9'h17F;            // last valid channel index
  localparam logic [8:0] BP_LAST   = 9'h0FF;            // last backplane channel

  // address regions, selected by addr[11:10]
  localparam logic [1:0] RGN_REGS  = 2'h0;              // control registers
  localparam logic [1:0] RGN_DMEM  = 2'h1;              // data memory, index addr[8:0]
  localparam logic [1:0] RGN_CM_LO = 2'h2;              // connection low byte (staged)
  localparam logic [1:0] RGN_CM_HI = 2'h3;              // connection high bits (commit)

  // register offsets inside RGN_REGS
  localparam logic [8:0] REG_CLK_MODE = 9'h000;         // clock_mode_register
  localparam logic [8:0] REG_CTRL     = 9'h001;         // control/status
  localparam logic [8:0] REG_FRAME_LO = 9'h002;         // frame state low byte
  localparam logic [8:0] REG_FRAME_HI = 9'h003;         // frame state high bits

  // field positions
  localparam int CLK_MODE_LSB = 0;                      // mode select [2:0]
  localparam int CLK_RATE_LSB = 3;                      // osc_input_rate_select [4:3]
  localparam int CTRL_BME     = 0;                      // bus_master_enable
  localparam int CTRL_SYNC    = 1;                      // sync seen, write one clears

  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic       BME_RST  = 1'b0;

  // clock modes
  typedef enum logic [2:0] {
    MODE_FREE    = 3'h0, MODE_SEC_FL  = 3'h1, MODE_EXA_FL = 3'h2, MODE_EXB_FL = 3'h3,
    MODE_BUS_SLV = 3'h4, MODE_SEC_PA  = 3'h5, MODE_EXA_PA = 3'h6, MODE_EXB_PA = 3'h7
  } tss_mode_t;

  // direct clock input rates
  typedef enum logic [1:0] {
    RATE_16M = 2'h0, RATE_8M = 2'h1, RATE_4M = 2'h2, RATE_RSV = 2'h3
  } tss_rate_t;

  // slot sequencer, one-hot
  typedef enum logic [3:0] {
    PH_CAPTURE = 4'h1, PH_FETCH = 4'h2, PH_EMIT = 4'h4, PH_IDLE = 4'h8
  } tss_phase_t;

  // connection memory entry, 12 bits
  typedef struct packed {
    logic       dir_ctl;  // pair_direction_bit, or control_output_stream timing
    logic       enable;   // driver enable, or dma enable
    logic       msg;      // message mode
    logic       amsb;     // data memory address msb
    logic [7:0] lo;       // address low byte or message byte
  } tss_cm_t;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tss_req_t;

  // per-slot output channel
  typedef struct packed {
    logic [8:0] chan;       // output channel index
    logic [7:0] data;       // sample or message byte
    logic       valid;      // one-cycle strobe
    logic       out_oe;     // drive bus_outbound_stream
    logic       in_oe;      // drive the inbound stream
    logic       dma_en;     // local channel dma transfer
    logic       ctl_stream; // control_output_stream timing
  } tss_chan_t;

  // pin synchroniser chains
  typedef struct packed {
    logic [2:0] osc;
    logic [2:0] frm;
    logic [2:0] c4;
    logic [2:0] sec;
    logic [2:0] exa;
    logic [2:0] exb;
  } tss_sync_t;

  // whole block state
  typedef struct packed {
    logic [NUM_CHAN-1:0][7:0] dmem;
    tss_cm_t [NUM_CHAN-1:0]   cmem;
    logic [7:0]  cm_stage;
    logic [2:0]  mode;
    logic [1:0]  rate;
    logic        bme;
    logic        sync_seen;
    logic [10:0] frame_cnt;
    tss_phase_t  phase;
    tss_cm_t     cur;
    logic [8:0]  cur_chan;
    logic        cur_act;
    logic [7:0]  cur_data;
    logic [1:0]  dpll_ph;
    logic [1:0]  osc_div;
    tss_sync_t   sy;
    tss_chan_t   chan;
    logic [7:0]  rdata;
    logic        apll_ref;
    logic        dpll_clk;
    logic        frame_out;
    logic        frm_o;
    logic        clk4_o;
    logic        clk2_o;
    logic        bus_oe;
  } tss_state_t;

endpackage

// ### src/tss_switch.sv
// time-slot switch with frame sequencer, digital pll and clock mode select
// assumes a single mclk domain; serial-to-parallel converters deliver bytes on mclk
//
// Functional notes
// - one byte per channel, fixed location
// - fixed write order, connection-ordered reads
// - 384 twelve-bit connection entries, same mapping
// - connection mode: 9-bit sample address
// - low byte staged, commit on high write
// - message mode sends low byte, ignores msb
// - many outputs may share one source
// - backplane bits: driver, mode, direction
// - local bits: dma, mode, control stream
// - direction bit picks driven side
// - processor data memory access, inputs override
// - frame machine free-runs or synchronises
// - digital pll omits or repeats periods
// - rate select sets direct clock divide
// - reset clears clock register, mode 0
// - mode 4 follows backplane clock, frame
// - modes 1-3 frequency locked only
// - modes 5-7 also phase aligned
// - drive bus timing only when master enabled
// - clock register selects eight modes
// - reset keeps both memories
`timescale 1ns/10ps

module tss_switch
  import tss_pkg::*;
(
  input  wire logic       mclk,            // master clock
  input  wire logic       rst_n,           // synchronous reset, active low
  input  wire tss_req_t   req,             // register port request
  output logic [7:0]      rdata,           // read data, cycle after read strobe
  input  wire logic [7:0] in_outbound,     // byte captured from bus_outbound_stream
  input  wire logic [7:0] in_inbound,      // byte captured from inbound or local stream
  output tss_chan_t       chan_out,        // per-slot output channel
  input  wire logic       osc_input_pin,   // direct clock input
  input  wire logic       bus_frame_pulse_i,
  output logic            bus_frame_pulse_o,
  output logic            bus_frame_pulse_oe,
  input  wire logic       bus_4m_clock_i,
  output logic            bus_4m_clock_o,
  output logic            bus_4m_clock_oe,
  output logic            bus_2m_clock_out,
  output logic            bus_2m_clock_oe,
  input  wire logic       secondary_frame_ref,
  input  wire logic       ext_frame_ref_a,
  input  wire logic       ext_frame_ref_b,
  output logic            frame_pulse_out, // local frame pulse, high the cycle after state 0
  output logic            apll_ref,        // selected analog pll reference
  output logic            dpll_clk         // digital pll 4.096 MHz output
);

  tss_state_t s_q;  // registered state
  tss_state_t s_d;  // next state

  // channel index lies inside the 384-entry memories
  function automatic logic chan_ok(input logic [8:0] idx);
    chan_ok = (idx <= CHAN_LAST);
  endfunction

  // rising edge seen between the second and third synchroniser stages
  function automatic logic rise(input logic [2:0] ch);
    rise = ch[1] & ~ch[2];
  endfunction

  // reference edge for a mode; the low two mode bits pick the source
  function automatic logic ref_edge(input logic [2:0] m, input tss_sync_t sy);
    unique case (m[1:0])
      2'h1:    ref_edge = rise(sy.sec);
      2'h2:    ref_edge = rise(sy.exa);
      2'h3:    ref_edge = rise(sy.exb);
      default: ref_edge = rise(sy.frm);
    endcase
  endfunction

  // next-state logic for the whole block
  always_comb
  begin
    logic [8:0]  idx;      // register port index
    logic [8:0]  slot;     // slot being captured
    logic [8:0]  src;      // data memory source address
    logic        sync_en;  // frame resync enabled by mode
    logic        dpll_on;  // digital pll in use
    logic        redge;    // selected reference edge
    logic        osc_rise; // direct clock rising edge
    logic        is_bp;    // current channel is backplane
    logic        rd_hit;   // read of a mapped location
    logic [7:0]  rd_val;   // value of that read
    idx      = req.addr[8:0];
    slot     = s_q.frame_cnt[10:2];
    src      = 9'h000;
    sync_en  = s_q.mode[2];
    dpll_on  = (s_q.mode != MODE_FREE) && (s_q.mode != MODE_BUS_SLV);
    redge    = ref_edge(s_q.mode, s_q.sy);
    osc_rise = rise(s_q.sy.osc);
    is_bp    = (s_q.cur_chan <= BP_LAST);
    rd_hit   = 1'b0;
    rd_val   = 8'h00;
    s_d      = s_q;

    // pin synchronisers: stage 0 feeds only stage 1
    s_d.sy.osc = {s_q.sy.osc[1:0], osc_input_pin};
    s_d.sy.frm = {s_q.sy.frm[1:0], bus_frame_pulse_i};
    s_d.sy.c4  = {s_q.sy.c4[1:0],  bus_4m_clock_i};
    s_d.sy.sec = {s_q.sy.sec[1:0], secondary_frame_ref};
    s_d.sy.exa = {s_q.sy.exa[1:0], ext_frame_ref_a};
    s_d.sy.exb = {s_q.sy.exb[1:0], ext_frame_ref_b};

    // frame sequencer: free-run, wrap at the last state or on a resync edge
    if (sync_en && redge)
    begin
      s_d.frame_cnt = 11'h000;
      s_d.phase     = PH_CAPTURE;
      s_d.sync_seen = 1'b1;
    end
    else if (s_q.frame_cnt == FRAME_LAST)
    begin
      s_d.frame_cnt = 11'h000;
      s_d.phase     = PH_CAPTURE;
    end
    else
    begin
      s_d.frame_cnt = s_q.frame_cnt + 11'h001;
      unique case (s_q.phase)
        PH_CAPTURE: s_d.phase = PH_FETCH;
        PH_FETCH:   s_d.phase = PH_EMIT;
        PH_EMIT:    s_d.phase = PH_IDLE;
        PH_IDLE:    s_d.phase = PH_CAPTURE;
        default:    s_d.phase = PH_CAPTURE;              // illegal code recovers
      endcase
    end

    // output strobe lasts one cycle
    s_d.chan.valid = 1'b0;

    // slot sequencing; a resync cuts the slot short and restarts at channel 0, dropping the rest of the frame
    unique case (s_q.phase)
      PH_CAPTURE:
      begin
        s_d.cur_act  = chan_ok(slot);
        s_d.cur_chan = slot;
        if (chan_ok(slot))
        begin
          s_d.cur = s_q.cmem[slot];
        end
      end
      PH_FETCH:
      begin
        // connection mode reads the 9-bit address, message mode the byte itself
        src = {s_q.cur.amsb, s_q.cur.lo};
        if (s_q.cur.msg)
        begin
          s_d.cur_data = s_q.cur.lo;
        end
        else if (chan_ok(src))
        begin
          s_d.cur_data = s_q.dmem[src];
        end
        else
        begin
          s_d.cur_data = 8'h00;                          // pointer past memory end
        end
      end
      PH_EMIT:
      begin
        if (s_q.cur_act)
        begin
          // capture the input side of the pair into its fixed location
          if (is_bp && !s_q.cur.dir_ctl)
          begin
            s_d.dmem[s_q.cur_chan] = in_outbound;
          end
          else
          begin
            s_d.dmem[s_q.cur_chan] = in_inbound;
          end
          s_d.chan.chan       = s_q.cur_chan;
          s_d.chan.data       = s_q.cur_data;
          s_d.chan.valid      = 1'b1;
          // backplane: enable gates the driver, direction picks the driven line
          s_d.chan.out_oe     = is_bp & s_q.cur.enable & s_q.cur.dir_ctl;
          s_d.chan.in_oe      = is_bp & s_q.cur.enable & ~s_q.cur.dir_ctl;
          // local: enable is dma, the top bit times the control stream
          s_d.chan.dma_en     = ~is_bp & s_q.cur.enable;
          s_d.chan.ctl_stream = ~is_bp & s_q.cur.dir_ctl;
        end
      end
      PH_IDLE:
      begin
        s_d.cur_act = 1'b0;
      end
      default:
      begin
        s_d.cur_act = 1'b0;
      end
    endcase

    // digital pll: divide by four, omit or repeat one state per reference edge
    if (dpll_on && redge && (s_q.dpll_ph != 2'h0))
    begin
      if (s_q.dpll_ph[1])
      begin
        s_d.dpll_ph = s_q.dpll_ph + 2'h2;                // late: omit a period
      end
      else
      begin
        s_d.dpll_ph = s_q.dpll_ph;                       // early: repeat a period
      end
    end
    else
    begin
      s_d.dpll_ph = s_q.dpll_ph + 2'h1;
    end
    s_d.dpll_clk = s_q.dpll_ph[1];

    // direct clock divider counts rising edges of the synchronised input
    if (osc_rise)
    begin
      s_d.osc_div = s_q.osc_div + 2'h1;
    end

    // analog pll reference by mode
    unique case (s_q.mode)
      MODE_FREE:
      begin
        unique case (s_q.rate)
          RATE_8M:  s_d.apll_ref = s_q.osc_div[0];
          RATE_4M:  s_d.apll_ref = s_q.sy.osc[1];
          default:  s_d.apll_ref = s_q.osc_div[1];
        endcase
      end
      MODE_BUS_SLV: s_d.apll_ref = s_q.sy.c4[1];
      default:      s_d.apll_ref = s_q.dpll_ph[1];
    endcase

    // backplane timing outputs, driven only as bus master
    s_d.frame_out = (s_q.frame_cnt == 11'h000);
    s_d.frm_o     = (s_q.frame_cnt == 11'h000);
    s_d.clk4_o    = s_q.frame_cnt[1];
    s_d.clk2_o    = s_q.frame_cnt[2];
    s_d.bus_oe    = s_q.bme;

    // register port reads answer in the next cycle only
    unique case (req.addr[11:10])
      RGN_REGS:
      begin
        unique case (idx)
          REG_CLK_MODE:
          begin
            rd_hit = 1'b1;
            rd_val = {3'h0, s_q.rate, s_q.mode};
          end
          REG_CTRL:
          begin
            rd_hit = 1'b1;
            rd_val = {6'h00, s_q.sync_seen, s_q.bme};
          end
          REG_FRAME_LO:
          begin
            rd_hit = 1'b1;
            rd_val = s_q.frame_cnt[7:0];
          end
          REG_FRAME_HI:
          begin
            rd_hit = 1'b1;
            rd_val = {5'h00, s_q.frame_cnt[10:8]};
          end
          default:
          begin
            rd_hit = 1'b0;
            rd_val = 8'h00;
          end
        endcase
      end
      RGN_DMEM:
      begin
        rd_hit = chan_ok(idx);
        rd_val = chan_ok(idx) ? s_q.dmem[idx] : 8'h00;
      end
      RGN_CM_LO:
      begin
        rd_hit = chan_ok(idx);
        rd_val = chan_ok(idx) ? s_q.cmem[idx].lo : 8'h00;
      end
      RGN_CM_HI:
      begin
        rd_hit = chan_ok(idx);
        rd_val = chan_ok(idx) ? {4'h0, s_q.cmem[idx][11:8]} : 8'h00;
      end
      default:
      begin
        rd_hit = 1'b0;
        rd_val = 8'h00;
      end
    endcase
    s_d.rdata = (req.rd && rd_hit) ? rd_val : 8'h00;

    // register port writes
    if (req.wr)
    begin
      unique case (req.addr[11:10])
        RGN_REGS:
        begin
          if (idx == REG_CLK_MODE)
          begin
            s_d.mode = req.wdata[CLK_MODE_LSB +: 3];
            s_d.rate = req.wdata[CLK_RATE_LSB +: 2];
          end
          else if (idx == REG_CTRL)
          begin
            // software must keep this clear in mode 4; the logic does not police it
            s_d.bme = req.wdata[CTRL_BME];
            // a resync edge in this same cycle keeps the flag set
            if (req.wdata[CTRL_SYNC] && !(sync_en && redge))
            begin
              s_d.sync_seen = 1'b0;
            end
          end
        end
        RGN_DMEM:
        begin
          // the sample capture below wins a same-slot collision
          if (chan_ok(idx))
          begin
            s_d.dmem[idx] = req.wdata;
          end
        end
        RGN_CM_LO:
        begin
          s_d.cm_stage = req.wdata;
        end
        RGN_CM_HI:
        begin
          if (chan_ok(idx))
          begin
            s_d.cmem[idx] = tss_cm_t'({req.wdata[3:0], s_q.cm_stage});
          end
        end
        default:
        begin
          s_d.cm_stage = s_q.cm_stage;
        end
      endcase
      // incoming serial data replaces a processor write to the same location
      if ((req.addr[11:10] == RGN_DMEM) && s_q.phase == PH_EMIT && s_q.cur_act
          && (idx == s_q.cur_chan))
      begin
        s_d.dmem[idx] = (is_bp && !s_q.cur.dir_ctl) ? in_outbound : in_inbound;
      end
    end

    // reset clears control state and leaves both memories alone
    if (!rst_n)
    begin
      s_d.cm_stage  = 8'h00;
      s_d.mode      = MODE_RST;
      s_d.rate      = RATE_RST;
      s_d.bme       = BME_RST;
      s_d.sync_seen = 1'b0;
      s_d.frame_cnt = 11'h000;
      s_d.phase     = PH_CAPTURE;
      s_d.cur       = '0;
      s_d.cur_chan  = 9'h000;
      s_d.cur_act   = 1'b0;
      s_d.cur_data  = 8'h00;
      s_d.dpll_ph   = 2'h0;
      s_d.osc_div   = 2'h0;
      s_d.sy        = '0;
      s_d.chan      = '0;
      s_d.rdata     = 8'h00;
      s_d.apll_ref  = 1'b0;
      s_d.dpll_clk  = 1'b0;
      s_d.frame_out = 1'b0;
      s_d.frm_o     = 1'b0;
      s_d.clk4_o    = 1'b0;
      s_d.clk2_o    = 1'b0;
      s_d.bus_oe    = 1'b0;
    end
  end

  // single state register; memories hold through reset, so the whole copy is taken
  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  // outputs come straight from state flip-flops
  assign rdata              = s_q.rdata;
  assign chan_out           = s_q.chan;
  assign bus_frame_pulse_o  = s_q.frm_o;
  assign bus_frame_pulse_oe = s_q.bus_oe;
  assign bus_4m_clock_o     = s_q.clk4_o;
  assign bus_4m_clock_oe    = s_q.bus_oe;
  assign bus_2m_clock_out   = s_q.clk2_o;
  assign bus_2m_clock_oe    = s_q.bus_oe;
  assign frame_pulse_out    = s_q.frame_out;
  assign apll_ref           = s_q.apll_ref;
  assign dpll_clk           = s_q.dpll_clk;

endmodule

// ### tb/tb.sv
// top bench: register port tasks, switching, clock mode and bus master tests
// assumes tss_switch alone with the bus model on its backplane side
`timescale 1ns/10ps

module tb;
  import tss_pkg::*;
  logic       mclk;
  logic       rst_n;
  tss_req_t   req;
  logic [7:0] rdata;
  tss_chan_t  chan_out;
  logic       frm_o, frm_oe, frm_i, c4_o, c4_oe, c4_i, c2, c2_oe;
  logic       c4_m, frm_m, frm_en, sec, exa, exb, fpo, aref, dclk;
  logic [7:0] ob, ib;
  int         bad_count;
  int         compares, k;
  // connection table: channel, high bits, low byte, expected byte
  logic [8:0] t_ch [5] = '{9'h00A, 9'h00B, 9'h00C, 9'h00D, 9'h12C};
  logic [3:0] t_hi [5] = '{4'hC, 4'h4, 4'h1, 4'h3, 4'hC};
  logic [7:0] t_lo [5] = '{8'h05, 8'h05, 8'h04, 8'h77, 8'h05};
  logic [7:0] t_ex [5] = '{8'hA5, 8'hA5, 8'h3C, 8'h77, 8'hA5};
  localparam logic [11:0] A_MODE = {RGN_REGS, 1'b0, REG_CLK_MODE};
  localparam logic [11:0] A_CTRL = {RGN_REGS, 1'b0, REG_CTRL};

  // wire level: the device where it drives, the model elsewhere
  assign c4_i  = c4_oe ? c4_o : c4_m;
  assign frm_i = frm_oe ? frm_o : frm_m;

  tss_switch dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .in_outbound(ob),
    .in_inbound(ib), .chan_out(chan_out), .osc_input_pin(1'b0), .bus_frame_pulse_i(frm_i),
    .bus_frame_pulse_o(frm_o), .bus_frame_pulse_oe(frm_oe), .bus_4m_clock_i(c4_i),
    .bus_4m_clock_o(c4_o), .bus_4m_clock_oe(c4_oe), .bus_2m_clock_out(c2),
    .bus_2m_clock_oe(c2_oe), .secondary_frame_ref(sec), .ext_frame_ref_a(exa),
    .ext_frame_ref_b(exb), .frame_pulse_out(fpo), .apll_ref(aref), .dpll_clk(dclk));

  tss_bus_model bus (.mclk(mclk), .rst_n(rst_n), .frm_en(frm_en), .clk_oe(c4_oe),
    .frm_oe(frm_oe), .c4_line(c4_m), .frm_line(frm_m), .ob_byte(ob), .ib_byte(ib));

  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // one-cycle read strobe, data looked at in the cycle after
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    chk($sformatf("rdata at %h", a), exp, rdata);
  endtask

  // connection entry: low byte first, then the committing high write
  task automatic cm(input logic [8:0] i, input logic [3:0] hi, input logic [7:0] lo);
    wr({RGN_CM_LO, 1'b0, i}, lo);
    wr({RGN_CM_HI, 1'b0, i}, {4'h0, hi});
  endtask

  // wait for one output channel strobe, bounded by a frame
  task automatic see(input logic [8:0] c, input logic [7:0] exp);
    int n;
    n = 0;
    while (!(chan_out.valid === 1'b1 && chan_out.chan === c) && n < 2100)
    begin
      @(negedge mclk);
      n++;
    end
    chk($sformatf("data of channel %0d", c), exp, (n < 2100) ? chan_out.data : ~exp);
  endtask

  // one reference edge
  task automatic pulse(input int sel);
    repeat (4) @(posedge mclk);
    {exb, exa, sec} <= 3'(1 << sel);
    repeat (8) @(posedge mclk);
    {exb, exa, sec} <= 3'h0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // hang guard
  initial
  begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] watchdog expected end seen hang");
    finish_test();
  end

  initial
  begin
    bad_count = 0;
    compares = 0;
    rst_n = 1'b0;
    req = '0;
    {exb, exa, sec} = 3'h0;
    frm_en = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(A_MODE, 8'h00);
    rd(A_CTRL, 8'h00);
    for (k = 0; k < NUM_CHAN; k++)
      cm(9'(k), 4'h0, 8'h00);
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      wr(A_MODE, 8'(k % 3 * 8 + k));
      rd(A_MODE, 8'(k % 3 * 8 + k));
    end
    wr(A_MODE, 8'h00);
    rd({RGN_REGS, 1'b0, 9'h010}, 8'h00);
    rd({RGN_DMEM, 1'b0, 9'h1FF}, 8'h00);
    $display("test modes done");
    cm(9'h005, 4'h2, 8'h00);
    cm(9'h104, 4'h2, 8'h00);
    for (k = 0; k < 5; k++)
      cm(t_ch[k], t_hi[k], t_lo[k]);
    repeat (2 * FRAME_STATES) @(posedge mclk);
    for (k = 0; k < 5; k++)
    begin
      see(t_ch[k], t_ex[k]);
      if (t_ch[k] > BP_LAST)
        chk("local flags", {6'h00, t_hi[k][2], t_hi[k][3]},
          {6'h00, chan_out.dma_en, chan_out.ctl_stream});
      else
        chk("drive flags", {6'h00, t_hi[k][2] & t_hi[k][3], t_hi[k][2] & ~t_hi[k][3]},
          {6'h00, chan_out.out_oe, chan_out.in_oe});
    end
    $display("test switching done");
    rd({RGN_DMEM, 1'b0, 9'h005}, 8'hA5);
    wr({RGN_DMEM, 1'b0, 9'h104}, 8'h11);
    repeat (FRAME_STATES) @(posedge mclk);
    rd({RGN_DMEM, 1'b0, 9'h104}, 8'h3C);
    $display("test data memory done");
    wr(A_CTRL, 8'h01);
    repeat (3) @(negedge mclk);
    chk("bus drive enables", 8'h07, {5'h00, c4_oe, frm_oe, c2_oe});
    rd(A_CTRL, 8'h01);
    wr(A_CTRL, 8'h00);
    $display("test bus master done");
    for (k = 1; k < 8; k++)
      if (k != 4)
      begin
        wr(A_MODE, 8'(k));
        pulse(k % 4 - 1);
        rd(A_CTRL, (k > 4) ? 8'h02 : 8'h00);
        wr(A_CTRL, 8'h02);
      end
    // slave mode, master enable clear
    wr(A_MODE, 8'h04);
    frm_en <= 1'b1;
    repeat (FRAME_STATES + 100) @(posedge mclk);
    rd(A_CTRL, 8'h02);
    frm_en <= 1'b0;
    wr(A_MODE, 8'h00);
    $display("test sync done");
    finish_test();
  end
endmodule

// ### tb/tss_bus_model.sv
// backplane model: free 4 MHz clock, gated frame pulse, fixed stream bytes
// assumes mclk at 40 MHz, so the bus clock half period is 5 cycles
`timescale 1ns/10ps

module tss_bus_model
  import tss_pkg::*;
#(
  parameter logic [7:0] OB_VAL = 8'hA5, // byte on the outbound stream
  parameter logic [7:0] IB_VAL = 8'h3C  // byte on the inbound stream
)
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  frm_en,   // bench lets frame pulses out
  input  wire logic  clk_oe,   // device drives the bus clock
  input  wire logic  frm_oe,   // device drives the frame line
  output logic       c4_line,
  output logic       frm_line,
  output logic [7:0] ob_byte,
  output logic [7:0] ib_byte
);
  logic [2:0]  half_q; // cycles in this clock half
  logic [10:0] fcnt_q; // position in the bus frame
  logic        c4_q;
  logic        frm_q;

  // clock and frame; pulses stay off unless asked, so no stray resync
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      half_q <= 3'h0;
      fcnt_q <= 11'h000;
      c4_q   <= 1'b0;
      frm_q  <= 1'b0;
    end
    else
    begin
      half_q <= (half_q == 3'h4) ? 3'h0 : half_q + 3'h1;
      c4_q   <= (half_q == 3'h4) ? ~c4_q : c4_q;
      fcnt_q <= fcnt_q + 11'h001;
      frm_q  <= frm_en && fcnt_q == 11'h000;
    end
  end

  // a line the device drives shows the inverse so a stale level is never mistaken
  assign c4_line  = clk_oe ? ~c4_q : c4_q;
  assign frm_line = frm_oe ? ~frm_q : frm_q;
  assign ob_byte  = OB_VAL;
  assign ib_byte  = IB_VAL;
endmodule

// ### tb/tss_switch_sva.sv
// checker for the time-slot switch: register reads, slot stream, frame period
// assumes one mclk domain; sees only the top ports and shadows the clock registers
`timescale 1ns/10ps

module tss_switch_sva
  import tss_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire tss_req_t   req,
  input wire logic [7:0] rdata,
  input wire tss_chan_t  chan_out,
  input wire logic       bus_frame_pulse_oe,
  input wire logic       bus_4m_clock_oe,
  input wire logic       bus_2m_clock_oe,
  input wire logic       frame_pulse_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [2:0]  mode_q; // shadow of the mode field
  logic [1:0]  rate_q; // shadow of the rate field
  logic        bme_q;  // shadow of bus_master_enable
  logic        free_q; // a frame pulse was seen in a free-running mode
  logic [11:0] gap_q;  // cycles since the last frame pulse
  logic        free_w; // no resync can have moved the frame
  logic        wr_mode;
  logic        wr_ctrl;

  assign free_w  = free_q && !mode_q[2];
  assign wr_mode = req.wr && req.addr == {RGN_REGS, 1'b0, REG_CLK_MODE};
  assign wr_ctrl = req.wr && req.addr == {RGN_REGS, 1'b0, REG_CTRL};

  // shadows follow software writes; modes 4 to 7 may resync, so they end free running
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RST;
      rate_q <= RATE_RST;
      bme_q  <= BME_RST;
      free_q <= 1'b0;
      gap_q  <= 12'h000;
    end
    else
    begin
      if (wr_mode)
        {rate_q, mode_q} <= req.wdata[4:0];
      if (wr_ctrl)
        bme_q <= req.wdata[0];
      if (mode_q[2])
        free_q <= 1'b0;
      else if (frame_pulse_out)
        free_q <= 1'b1;
      gap_q <= frame_pulse_out ? 12'h000 : gap_q + 12'h001;
    end
  end

  a_frame_period: assert property (free_w |-> frame_pulse_out == (gap_q == 12'h7FF))
    else $error("frame pulse not 2048 cycles apart");
  a_mode_read: assert property (req.rd && req.addr == {RGN_REGS, 1'b0, REG_CLK_MODE}
    |=> rdata == {3'h0, rate_q, mode_q}) else $error("clock mode read back wrong");
  a_ctrl_read: assert property (req.rd && req.addr == {RGN_REGS, 1'b0, REG_CTRL}
    |=> rdata[7:2] == 6'h00 && rdata[0] == bme_q) else $error("control read back wrong");
  a_valid_gap: assert property (free_w && chan_out.valid |=> !chan_out.valid [*3])
    else $error("channel strobes closer than four cycles");
  a_chan_next: assert property (free_w && chan_out.valid && chan_out.chan != CHAN_LAST
    |-> ##4 chan_out.valid && chan_out.chan == $past(chan_out.chan, 4) + 9'h001)
    else $error("output channel order broken");
  a_chan_range: assert property (chan_out.valid |-> chan_out.chan <= CHAN_LAST)
    else $error("strobe for a channel beyond the last");
  a_dir_excl: assert property (!(chan_out.out_oe && chan_out.in_oe))
    else $error("both pair directions driven");
  a_local_quiet: assert property (chan_out.valid && chan_out.chan > BP_LAST
    |-> !chan_out.out_oe && !chan_out.in_oe) else $error("local channel drives backplane");
  a_oe_off: assert property (!bme_q && !$past(bme_q)
    |-> !bus_4m_clock_oe && !bus_frame_pulse_oe && !bus_2m_clock_oe)
    else $error("bus timing driven without master enable");
  a_oe_on: assert property (bme_q && $past(bme_q)
    |-> bus_4m_clock_oe && bus_frame_pulse_oe && bus_2m_clock_oe)
    else $error("bus timing not driven as master");
endmodule

bind tss_switch tss_switch_sva chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
  .chan_out(chan_out), .bus_frame_pulse_oe(bus_frame_pulse_oe),
  .bus_4m_clock_oe(bus_4m_clock_oe), .bus_2m_clock_oe(bus_2m_clock_oe),
  .frame_pulse_out(frame_pulse_out));
